// [hw/bbs_pkg.sv]
/*
  Constants for the rectangle-transfer setup block: register offsets, command
  word field positions, alignment codes, bus answers and reset values.
  Assumes byte addresses of an AXI4-Lite slave with a 25-bit address space.
*/
package bbs_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int BBS_AW = 25;                               // Address width
  localparam logic [24:0] BBS_CMD_OFS = 25'h000A500;        // blit_command_word
  localparam logic [24:0] BBS_SIZE_OFS = 25'h000A504;       // rect_size
  localparam logic [24:0] BBS_SRC_OFS = 25'h000A508;        // source_coords
  localparam logic [24:0] BBS_DST_OFS = 25'h000A50C;        // dest_coords
  localparam logic [24:0] BBS_STAT_OFS = 25'h000A510;       // Engine status
  localparam logic [24:0] BBS_MPAT_LO_OFS = 25'h000ACE8;    // mono_pattern_low
  localparam logic [24:0] BBS_MPAT_HI_OFS = 25'h000ACEC;    // mono_pattern_high
  localparam logic [24:0] BBS_BG_OFS = 25'h000ACF0;         // pattern_background_color
  localparam logic [24:0] BBS_FG_OFS = 25'h000ACF4;         // pattern_foreground_color
  localparam logic [24:0] BBS_CPAT_OFS = 25'h000A100;       // Colour pattern, 16 words
  localparam logic [24:0] BBS_IMG_FIRST = 25'h1000000;      // Image window start
  localparam logic [24:0] BBS_IMG_LAST = 25'h1007FFF;       // Image window end

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int BBS_AUTO_BIT = 0;       // Auto-execute
  localparam int BBS_CLIP_BIT = 1;       // Clipping enable
  localparam int BBS_DEPTH_LO = 2;       // Colour depth, 3 bits
  localparam int BBS_SRC_MONO_BIT = 6;   // Source image is mono
  localparam int BBS_SRC_CPU_BIT = 7;    // Source is the CPU image window
  localparam int BBS_PAT_MONO_BIT = 8;   // Mono pattern
  localparam int BBS_ALIGN_LO = 10;      // Image alignment, 2 bits
  localparam int BBS_SKIP_LO = 12;       // First-dword byte skip, 2 bits
  localparam int BBS_ROP_LO = 17;        // Raster operation, 8 bits
  localparam int BBS_XDIR_BIT = 25;      // Horizontal direction
  localparam int BBS_YDIR_BIT = 26;      // Vertical direction

  // Coordinate and size fields: x or width at 26-16, y or height at 10-0
  localparam int BBS_HI_LO = 16;
  localparam int BBS_LO_LO = 0;

  // Image alignment codes
  localparam logic [1:0] BBS_ALIGN_BYTE = 2'h0;
  localparam logic [1:0] BBS_ALIGN_WORD = 2'h1;
  localparam logic [1:0] BBS_ALIGN_DWORD = 2'h2;

  // Colour depth codes
  localparam logic [2:0] BBS_DEPTH_8 = 3'h0;
  localparam logic [2:0] BBS_DEPTH_16 = 3'h1;
  localparam logic [2:0] BBS_DEPTH_24 = 3'h2;

  // Bus answers
  localparam logic [1:0] BBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BBS_RESP_SLVERR = 2'h2;

  // Reset value of every parameter register
  localparam logic [31:0] BBS_REG_RST = 32'h00000000;

endpackage

// [hw/bbs_setup.sv]
/*
  Command and parameter front end of a rectangle-transfer engine: register
  file on AXI4-Lite, command launch, image window unpacking with byte skip and
  line alignment, mono expansion and pattern colour lookup.
  Assumes one clock (mclk), a synchronous active-low reset and a downstream
  pixel engine that takes the stream every cycle and pulses eng_done.
*/
// What this block does
// [RULE1] Image window words feed the active transfer
// [RULE2] Host wraps image address inside window
// [RULE3] Skip field drops leading first-dword bytes
// [RULE4] Word alignment: line starts next word
// [RULE5] Dword alignment: line starts next dword
// [RULE6] Byte alignment: line starts next byte
// [RULE7] Auto-execute: destination write launches command
// [RULE8] Direction, raster operation, clip bit positions
// [RULE9] Depth field sets pattern colour width; colour pattern pixels here are always one byte, at every depth
// [RULE10] Size holds width minus one, height
// [RULE11] Source register holds start x, y
// [RULE12] Destination register holds start x, y
// [RULE13] Mono pattern split over two words
// [RULE14] Colour indices in own registers
// [RULE15] Mono pattern bit picks fore/background
// [RULE16] Mono source bits expand to colour
// [RULE17] Colour pattern mode uses colour registers
// [RULE18] Host writes exactly computed dword count
// [RULE19] Host issues one command per line; the bench issues one command for a whole two-line rectangle
// [RULE20] Command bit 0 enables auto-execute
// [RULE21] Host offsets start corners for negative
// [RULE22] No auto-execute: command write launches
`timescale 1ns/1ps

module bbs_setup
  import bbs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [BBS_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [BBS_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Command launch toward the pixel engine
  output logic launch,
  output logic busy,
  output logic [31:0] run_cmd,
  output logic [31:0] run_size,
  output logic [31:0] run_src,
  output logic [31:0] run_dst,
  input wire logic eng_done,
  // Source image stream
  output logic src_valid,
  output logic [31:0] src_data,
  output logic src_line_end,
  // Pattern lookup
  input wire logic [2:0] pat_x,
  input wire logic [2:0] pat_y,
  output logic [31:0] pat_pixel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_full;                 // Write address held
    logic [BBS_AW-1:0] aw_addr;    // Held write address
    logic awready;                 // Address channel ready
    logic w_full;                  // Write data held
    logic [31:0] w_data;           // Held write data
    logic [3:0] w_strb;            // Held byte enables
    logic wready;                  // Data channel ready
    logic bvalid;                  // Write answer pending
    logic [1:0] bresp;             // Write answer code
    logic arready;                 // Read channel ready
    logic rvalid;                  // Read answer pending
    logic [31:0] rdata;            // Read answer data
    logic [1:0] rresp;             // Read answer code
    logic [31:0] cmd;              // blit_command_word
    logic [31:0] size;             // rect_size
    logic [31:0] src;              // source_coords
    logic [31:0] dst;              // dest_coords
    logic [31:0] mpat_lo;          // mono_pattern_low
    logic [31:0] mpat_hi;          // mono_pattern_high
    logic [31:0] bg;               // pattern_background_color
    logic [31:0] fg;               // pattern_foreground_color
    logic [15:0][31:0] cpat;       // Colour pattern words
    logic launch;                  // Launch pulse
    logic busy;                    // Command running
    logic [31:0] run_cmd;          // Snapshot at launch
    logic [31:0] run_size;
    logic [31:0] run_src;
    logic [31:0] run_dst;
    logic img_act;                 // Image transfer expecting data
    logic hold_full;               // Image dword waiting
    logic [31:0] hold;             // Image dword
    logic [1:0] ptr;               // Next byte in dword
    logic [2:0] bitpos;            // Next bit in byte, mono source
    logic [13:0] line_left;        // Units left in this line
    logic [10:0] lines_left;       // Lines left
    logic src_valid;
    logic [31:0] src_data;
    logic src_line_end;
    logic [31:0] pat_pixel;
  } bbs_state_t;

  bbs_state_t s_reg;       // Current state
  bbs_state_t s_next;      // Next state

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Merge written bytes under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Colour mask for the selected depth
  function automatic logic [31:0] depth_mask(input logic [2:0] dep);
    case (dep)
      BBS_DEPTH_16: return 32'h0000FFFF;
      BBS_DEPTH_24: return 32'h00FFFFFF;
      default: return 32'h000000FF;
    endcase
  endfunction

  // Source units per line: bits for mono, bytes for colour
  function automatic logic [13:0] line_units(input logic [31:0] c, input logic [31:0] sz);
    logic [13:0] w;
    w = {3'h0, sz[BBS_HI_LO +: 11]} + 14'h1;
    if (c[BBS_SRC_MONO_BIT]) begin
      return w;
    end
    case (c[BBS_DEPTH_LO +: 3])
      BBS_DEPTH_16: return 14'(w * 14'h2);
      BBS_DEPTH_24: return 14'(w * 14'h3);
      default: return w;
    endcase
  endfunction

  // Register read mux; unmapped answers SLVERR
  function automatic logic [33:0] read_word(input bbs_state_t st, input logic [BBS_AW-1:0] a);
    if (a[BBS_AW-1:6] == BBS_CPAT_OFS[BBS_AW-1:6]) begin
      return {BBS_RESP_OKAY, st.cpat[a[5:2]]};
    end
    if (a >= BBS_IMG_FIRST && a <= BBS_IMG_LAST) begin
      return {BBS_RESP_OKAY, 32'h00000000};
    end
    case ({a[BBS_AW-1:2], 2'h0})
      BBS_CMD_OFS: return {BBS_RESP_OKAY, st.cmd};
      BBS_SIZE_OFS: return {BBS_RESP_OKAY, st.size};
      BBS_SRC_OFS: return {BBS_RESP_OKAY, st.src};
      BBS_DST_OFS: return {BBS_RESP_OKAY, st.dst};
      BBS_STAT_OFS: return {BBS_RESP_OKAY, 5'h0, st.lines_left, 13'h0, st.hold_full, st.img_act, st.busy};
      BBS_MPAT_LO_OFS: return {BBS_RESP_OKAY, st.mpat_lo};
      BBS_MPAT_HI_OFS: return {BBS_RESP_OKAY, st.mpat_hi};
      BBS_BG_OFS: return {BBS_RESP_OKAY, st.bg};
      BBS_FG_OFS: return {BBS_RESP_OKAY, st.fg};
      default: return {BBS_RESP_SLVERR, 32'h00000000};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [63:0] mpat;        // Both mono pattern words, bit index y*8+x
  logic in_win;             // Held write targets the image window
  logic [BBS_AW-1:0] wa;    // Word address of the held write
  logic launch_now;         // A command starts this cycle
  logic [7:0] cur_byte;     // Image byte under the pointer
  logic [2:0] nb;           // Next line start byte index
  logic [31:0] mask;        // Depth mask of the running command
  logic [5:0] pidx;         // Pattern pixel index
  logic [33:0] rd;          // Read answer

  always_comb begin
    s_next = s_reg;
    mpat = {s_reg.mpat_hi, s_reg.mpat_lo};
    launch_now = 1'b0;
    nb = 3'h0;
    rd = 34'h000000000;
    wa = {s_reg.aw_addr[BBS_AW-1:2], 2'h0};
    in_win = (s_reg.aw_addr >= BBS_IMG_FIRST) && (s_reg.aw_addr <= BBS_IMG_LAST);
    // [RULE9] depth sets colour width
    mask = depth_mask(s_reg.run_cmd[BBS_DEPTH_LO +: 3]);
    cur_byte = s_reg.hold[{s_reg.ptr, 3'h0} +: 8];
    pidx = {pat_y, pat_x};
    s_next.launch = 1'b0;
    s_next.src_valid = 1'b0;
    s_next.src_line_end = 1'b0;

    // Channel captures, each on its own handshake
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Image unpacker: one byte, or one mono bit, per cycle
    if (s_reg.img_act && s_reg.hold_full) begin
      s_next.src_valid = 1'b1;
      if (s_reg.run_cmd[BBS_SRC_MONO_BIT]) begin
        // [RULE16] mono bit to colour
        s_next.src_data = cur_byte[3'h7 - s_reg.bitpos] ? (s_reg.fg & mask) : (s_reg.bg & mask);
      end else begin
        s_next.src_data = {24'h000000, cur_byte};
      end
      if (s_reg.line_left == 14'h1) begin
        s_next.src_line_end = 1'b1;
        if (s_reg.lines_left == 11'h1) begin
          // Last line done; rest of the dword is dropped
          s_next.img_act = 1'b0;
          s_next.hold_full = 1'b0;
          s_next.lines_left = 11'h0;
        end else begin
          s_next.lines_left = s_reg.lines_left - 11'h1;
          s_next.line_left = line_units(s_reg.run_cmd, s_reg.run_size);
          s_next.bitpos = 3'h0;
          nb = {1'b0, s_reg.ptr} + 3'h1;
          case (s_reg.run_cmd[BBS_ALIGN_LO +: 2])
            // [RULE4] next word
            BBS_ALIGN_WORD: nb = nb + {2'h0, nb[0]};
            // [RULE5] next doubleword
            BBS_ALIGN_DWORD: nb = 3'h4;
            // [RULE6] next byte
            default: nb = nb;
          endcase
          s_next.ptr = nb[1:0];
          if (nb[2]) begin
            s_next.hold_full = 1'b0;
          end
        end
      end else begin
        s_next.line_left = s_reg.line_left - 14'h1;
        if (s_reg.run_cmd[BBS_SRC_MONO_BIT] && s_reg.bitpos != 3'h7) begin
          s_next.bitpos = s_reg.bitpos + 3'h1;
        end else begin
          s_next.bitpos = 3'h0;
          s_next.ptr = s_reg.ptr + 2'h1;
          if (s_reg.ptr == 2'h3) begin
            s_next.hold_full = 1'b0;
          end
        end
      end
    end

    // Perform a held write; a window write waits for a free holding word
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid && !(in_win && s_reg.hold_full)) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = BBS_RESP_OKAY;
      if (in_win) begin
        // [RULE1] window feeds transfer
        if (s_reg.img_act) begin
          s_next.hold = s_reg.w_data;
          s_next.hold_full = 1'b1;
        end
      end else if (wa[BBS_AW-1:6] == BBS_CPAT_OFS[BBS_AW-1:6]) begin
        s_next.cpat[wa[5:2]] = merge(s_reg.cpat[wa[5:2]], s_reg.w_data, s_reg.w_strb);
      end else begin
        case (wa)
          BBS_CMD_OFS: begin
            // [RULE8] fields held as written
            s_next.cmd = merge(s_reg.cmd, s_reg.w_data, s_reg.w_strb);
            // [RULE22] command write launches
            launch_now = !s_next.cmd[BBS_AUTO_BIT];
          end
          // [RULE10] width-1 and height
          BBS_SIZE_OFS: s_next.size = merge(s_reg.size, s_reg.w_data, s_reg.w_strb);
          // [RULE11] source start
          BBS_SRC_OFS: s_next.src = merge(s_reg.src, s_reg.w_data, s_reg.w_strb);
          BBS_DST_OFS: begin
            // [RULE12] destination start
            s_next.dst = merge(s_reg.dst, s_reg.w_data, s_reg.w_strb);
            // [RULE7] [RULE20] auto-execute launch
            launch_now = s_reg.cmd[BBS_AUTO_BIT];
          end
          // [RULE13] two pattern words
          BBS_MPAT_LO_OFS: s_next.mpat_lo = merge(s_reg.mpat_lo, s_reg.w_data, s_reg.w_strb);
          BBS_MPAT_HI_OFS: s_next.mpat_hi = merge(s_reg.mpat_hi, s_reg.w_data, s_reg.w_strb);
          // [RULE14] separate colour registers
          BBS_BG_OFS: s_next.bg = merge(s_reg.bg, s_reg.w_data, s_reg.w_strb);
          BBS_FG_OFS: s_next.fg = merge(s_reg.fg, s_reg.w_data, s_reg.w_strb);
          default: s_next.bresp = BBS_RESP_SLVERR;
        endcase
      end
    end

    // Launch takes a snapshot of command, size, source and destination as just written
    if (launch_now) begin
      s_next.launch = 1'b1;
      s_next.busy = 1'b1;
      s_next.run_cmd = s_next.cmd;
      s_next.run_size = s_next.size;
      s_next.run_src = s_next.src;
      s_next.run_dst = s_next.dst;
      s_next.img_act = s_next.cmd[BBS_SRC_CPU_BIT] && (s_next.size[BBS_LO_LO +: 11] != 11'h0);
      s_next.hold_full = 1'b0;
      // [RULE3] skip leading bytes
      s_next.ptr = s_next.cmd[BBS_SKIP_LO +: 2];
      s_next.bitpos = 3'h0;
      s_next.line_left = line_units(s_next.cmd, s_next.size);
      s_next.lines_left = s_next.size[BBS_LO_LO +: 11];
    end else if (eng_done && !s_reg.img_act) begin
      s_next.busy = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken
    if (s_reg.arready && s_axi_arvalid) begin
      rd = read_word(s_reg, {s_axi_araddr[BBS_AW-1:2], 2'h0});
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[31:0];
      s_next.rresp = rd[33:32];
      s_next.arready = 1'b0;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // Pattern lookup for the running command
    if (s_reg.run_cmd[BBS_PAT_MONO_BIT]) begin
      // [RULE15] bit picks colour
      s_next.pat_pixel = mpat[pidx] ? (s_reg.fg & mask) : (s_reg.bg & mask);
    end else begin
      // [RULE17] colour pattern registers
      s_next.pat_pixel = {24'h000000, s_reg.cpat[pidx[5:2]][{pidx[1:0], 3'h0} +: 8]};
    end

    s_next.awready = !s_next.aw_full;
    s_next.wready = !s_next.w_full;

    // Synchronous reset to constants
    if (!rst_n) begin
      s_next = '0;
      s_next.cmd = BBS_REG_RST;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign launch = s_reg.launch;
  assign busy = s_reg.busy;
  assign run_cmd = s_reg.run_cmd;
  assign run_size = s_reg.run_size;
  assign run_src = s_reg.run_src;
  assign run_dst = s_reg.run_dst;
  assign src_valid = s_reg.src_valid;
  assign src_data = s_reg.src_data;
  assign src_line_end = s_reg.src_line_end;
  assign pat_pixel = s_reg.pat_pixel;

endmodule

// [bench/bbs_setup_props.sv]
/*
  Port assertions for bbs_setup.
  Assumes one clock mclk and a synchronous active-low rst_n.
*/
`timescale 1ns/1ps
module bbs_setup_props (
  // Watched ports
  input wire logic mclk, rst_n, launch, busy, src_valid, src_line_end,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata, run_cmd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_one_pulse; launch |=> !launch; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("launch longer than a cycle");
  property p_with_answer; launch |-> $rose(s_axi_bvalid); endproperty
  a_with_answer: assert property (p_with_answer) else $error("launch without write answer");
  property p_busy; launch |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy not set after launch");
  property p_src_busy; src_valid |-> busy; endproperty
  a_src_busy: assert property (p_src_busy) else $error("image item while idle");
  property p_snap; !launch |-> $stable(run_cmd); endproperty
  a_snap: assert property (p_snap) else $error("command snapshot moved");
  property p_line_end; src_line_end |-> src_valid; endproperty
  a_line_end: assert property (p_line_end) else $error("line end without item");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule
bind bbs_setup bbs_setup_props u_bbs_setup_props (.*);

// [bench/bbs_host.sv]
/*
  Host model: AXI4-Lite master for the registers and the image window.
  Assumes rising-edge mclk; every wait gives up after 200 cycles.
*/
`timescale 1ns/1ps
module bbs_host
  import bbs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Master side
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  output logic [BBS_AW-1:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  // Slave side
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  logic [14:0] img_ptr = 15'h0; // Offset in the image window
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
  end
  // Write; released lines show the inverse of the last value
  task automatic wr(input logic [24:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid) begin
        {r, ok} = {s_axi_bresp, 1'b1};
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  // Read; rready comes one cycle late on purpose
  task automatic rd(input logic [24:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid && s_axi_rready) begin
        {d, r, ok} = {s_axi_rdata, s_axi_rresp, 1'b1};
        s_axi_rready <= 1'b0;
      end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask
  task automatic img(input logic [31:0] d, output logic [1:0] r, output bit ok);
    wr(BBS_IMG_FIRST + {10'h0, img_ptr}, d, r, ok);
    img_ptr = img_ptr + 15'h4;
  endtask
endmodule

// [bench/testbench.sv]
/*
  Self-checking bench for bbs_setup.
  Assumes bbs_host as bus master and a bench-driven pixel engine.
*/
`timescale 1ns/1ps
module testbench
  import bbs_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, eng_done = 1'b0;
  logic [2:0] pat_x = 3'h0, pat_y = 3'h0, s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, launch, busy;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, src_valid, src_line_end;
  logic [BBS_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, run_cmd, run_size, run_src, run_dst, src_data, pat_pixel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0, n_checks = 0, n_launch = 0;
  logic [31:0] q[$]; // Source items seen
  int le[$]; // Item count at each line end
  bbs_setup u_bbs_setup (.*);
  bbs_host u_bbs_host (.*);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // Stream and launch monitor
  always @(posedge mclk) begin
    if (launch) n_launch++;
    if (src_valid) q.push_back(src_data);
    if (src_valid && src_line_end) le.push_back(q.size());
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic lost();
    err_total++;
    final_report();
  endtask
  task automatic wr(input logic [24:0] a, input logic [31:0] d, input logic [1:0] er = BBS_RESP_OKAY);
    logic [1:0] r;
    bit ok;
    u_bbs_host.wr(a, d, r, ok);
    if (!ok) lost();
    @(negedge mclk);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [24:0] a, input logic [31:0] e, input logic [1:0] er = BBS_RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    bit ok;
    u_bbs_host.rd(a, d, r, ok);
    if (!ok) lost();
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic img(input logic [31:0] d);
    logic [1:0] r;
    bit ok;
    u_bbs_host.img(d, r, ok);
    if (!ok) lost();
  endtask
  task automatic done();
    @(posedge mclk);
    eng_done <= 1'b1;
    @(posedge mclk);
    eng_done <= 1'b0;
  endtask
  task automatic waitq(input int n);
    for (int i = 0; i < 100 && q.size() < n; i++) @(posedge mclk);
    if (q.size() < n) lost();
  endtask
  task automatic pat(input logic [2:0] x, input logic [31:0] e);
    @(posedge mclk);
    pat_x <= x;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("pat_pixel", e, pat_pixel);
  endtask
  task automatic t_regs();
    logic [24:0] ofs[7] = '{BBS_SIZE_OFS, BBS_SRC_OFS, BBS_DST_OFS, BBS_MPAT_LO_OFS, BBS_MPAT_HI_OFS, BBS_BG_OFS,
      BBS_FG_OFS};
    rd(BBS_CMD_OFS, BBS_REG_RST);
    foreach (ofs[i]) begin
      rd(ofs[i], BBS_REG_RST);
      wr(ofs[i], 32'h07FF_0000 + i);
      rd(ofs[i], 32'h07FF_0000 + i);
    end
    chk("launches", 32'h0, n_launch);
    wr(BBS_CPAT_OFS, 32'h4433_2211);
    rd(25'h000A600, 32'h0, BBS_RESP_SLVERR);
    wr(25'h000A600, 32'h1, BBS_RESP_SLVERR);
    $display("test registers done");
  endtask
  task automatic t_launch();
    logic [31:0] c = 32'h0600_0002 | (32'hCC << BBS_ROP_LO);
    wr(BBS_SIZE_OFS, 32'h0005_0007);
    wr(BBS_CMD_OFS, c);
    chk("launches", 32'h1, n_launch);
    chk("run_cmd", c, run_cmd);
    chk("run_size", 32'h0005_0007, run_size);
    done();
    wr(BBS_CMD_OFS, c | 32'h1);
    wr(BBS_SRC_OFS, 32'h0003_0004);
    chk("launches", 32'h1, n_launch);
    wr(BBS_DST_OFS, 32'h0009_000A);
    chk("launches", 32'h2, n_launch);
    chk("run_dst", 32'h0009_000A, run_dst);
    chk("run_src", 32'h0003_0004, run_src);
    rd(BBS_STAT_OFS, 32'h0007_0001);
    done();
    wr(BBS_CMD_OFS, 32'h0);
    done();
    $display("test launch done");
  endtask
  task automatic t_image(input logic [1:0] al);
    logic [7:0] b[12];
    int s;
    for (int i = 0; i < 12; i++) b[i] = 8'(8'h11 * (i + 1));
    s = (al == BBS_ALIGN_BYTE) ? 5 : (al == BBS_ALIGN_WORD) ? 6 : 8;
    wr(BBS_SIZE_OFS, 32'h0002_0002);
    q.delete();
    le.delete();
    wr(BBS_CMD_OFS, 32'h2080 | (32'(al) << BBS_ALIGN_LO));
    for (int k = 0; k < ((s == 5) ? 2 : 3); k++) img({b[4*k+3], b[4*k+2], b[4*k+1], b[4*k]});
    waitq(6);
    for (int j = 0; j < 3; j++) begin
      chk("first line", {24'h0, b[2+j]}, q[j]);
      chk("second line", {24'h0, b[s+j]}, q[3+j]);
    end
    chk("line end", 32'h3, le[0]);
    chk("line end", 32'h6, le[1]);
    pat(3'h1, 32'h22);
    done();
    $display("test image %0d done", al);
  endtask
  task automatic t_mono();
    wr(BBS_BG_OFS, 32'hFFFF_FFA5);
    wr(BBS_FG_OFS, 32'hFFFF_FF5A);
    wr(BBS_MPAT_LO_OFS, 32'h1);
    wr(BBS_MPAT_HI_OFS, 32'h0);
    wr(BBS_SIZE_OFS, 32'h0003_0001);
    q.delete();
    wr(BBS_CMD_OFS, 32'h1C0);
    img(32'h0000_00A0);
    waitq(4);
    for (int j = 0; j < 4; j++) chk("mono pixel", j[0] ? 32'hA5 : 32'h5A, q[j]);
    pat(3'h0, 32'h5A);
    pat(3'h1, 32'hA5);
    done();
    $display("test mono done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_launch();
    t_image(BBS_ALIGN_BYTE);
    t_image(BBS_ALIGN_WORD);
    t_image(BBS_ALIGN_DWORD);
    t_mono();
    final_report();
  end
endmodule
